/* File: src/usbpp_core.sv */
// top of usb config, line coding and ping-pong pointer logic
// assumes a one-cycle strobe register port, read data one cycle later
`timescale 1ns/1ps
`include "usbpp_params.svh"
module usbpp_core
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// engine events
	input wire logic eng_tx_active,
	input wire logic eng_tx_se0,
	input wire logic eng_tx_bit,
	input wire logic eng_done,
	input wire logic [3:0] eng_done_ep,
	input wire logic eng_done_dir_in,
	input wire logic bus_idle_seen,
	input wire logic bus_activity_seen,
	input wire logic pll_locked,
	// transceiver
	input wire logic rx_plus_in,
	input wire logic rx_minus_in,
	output logic tx_plus_out,
	output logic tx_minus_out,
	output logic xcvr_drive_enable_n,
	// analog controls and monitor
	output logic pullup_on,
	output logic regulator_on,
	output logic drive_monitor,
	output logic module_ready
);
	import usbpp_pkg::*;
	logic [7:0] cfg_r;
	logic [7:0] ctl_r;
	logic actv_flag_r;
	logic idle_flag_r;
	logic actv_armed_r;
	logic parity_r;
	logic [3:0] stat_ep_r;
	logic stat_dir_r;
	logic [2:0] wake_cnt_r;
	logic eye_phase_r;
	logic eye_prime_r;
	logic tx_active;
	logic tx_se0;
	logic tx_bit;
	logic [`USBPP_NUM_EP-1:0] ptr_odd;
	usbpp_line_t line_state;
	usbpp_ppmode_t pp_mode;
	logic enable_rise;
	logic ptr_clear;
	logic actv_clear_ok;
	logic wr_cfg;
	logic wr_ctl;
	logic wr_irq;
	logic eye_on;
	logic [5:0] desc_idx;

	assign wr_cfg = reg_wr && reg_addr == `USBPP_ADDR_CFG;
	assign wr_ctl = reg_wr && reg_addr == `USBPP_ADDR_CTL;
	assign wr_irq = reg_wr && reg_addr == `USBPP_ADDR_IRQ;
	assign pp_mode = usbpp_ppmode_t'(cfg_r[`USBPP_CFG_PPMODE_LO +: 2]);
	assign eye_on = cfg_r[`USBPP_CFG_EYE] && ctl_r[`USBPP_CTL_ENABLE];

	////////////////////////////////////////////////////////////////
	// configuration and control registers
	// config reset keeps pull-up and regulator off
	always_ff @(posedge core_clk)
	begin
		if (reset)
			cfg_r <= 8'h00;
		else if (wr_cfg)
			cfg_r <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			ctl_r <= 8'h00;
		else if (wr_ctl)
			ctl_r <= reg_wdata;
	end

	assign enable_rise = wr_ctl && reg_wdata[`USBPP_CTL_ENABLE] && !ctl_r[`USBPP_CTL_ENABLE];
	// reset pointers on enable or pointer reset
	assign ptr_clear = enable_rise || ctl_r[`USBPP_CTL_PTRRST];

	////////////////////////////////////////////////////////////////
	// eye pattern generator
	// one prime cycle emulates rx-to-tx switch, then alternates
	always_ff @(posedge core_clk)
	begin
		if (reset || !eye_on)
		begin
			eye_prime_r <= 1'b1;
			eye_phase_r <= 1'b0;
		end
		else
		begin
			eye_prime_r <= 1'b0;
			eye_phase_r <= eye_prime_r ? 1'b0 : ~eye_phase_r;
		end
	end

	// low-speed J and full-speed K are both diff zero, so either pattern opens on diff zero
	assign tx_active = eye_on ? !eye_prime_r : eng_tx_active;
	assign tx_se0 = eye_on ? 1'b0 : eng_tx_se0;
	assign tx_bit = eye_on ? eye_phase_r : eng_tx_bit;

	usbpp_line_codec u_codec
	(
		.core_clk(core_clk),
		.reset(reset),
		.tx_active(tx_active),
		.tx_se0(tx_se0),
		.tx_bit(tx_bit),
		.rx_plus_in(rx_plus_in),
		.rx_minus_in(rx_minus_in),
		.tx_plus_out(tx_plus_out),
		.tx_minus_out(tx_minus_out),
		.xcvr_drive_enable_n(xcvr_drive_enable_n),
		.line_state(line_state)
	);

	usbpp_ptr_bank u_ptrs
	(
		.core_clk(core_clk),
		.reset(reset),
		.clear_all(ptr_clear),
		.pp_mode(pp_mode),
		.done_pulse(eng_done),
		.done_ep(eng_done_ep),
		.done_dir_in(eng_done_dir_in),
		.ptr_odd(ptr_odd)
	);

	////////////////////////////////////////////////////////////////
	// transfer status
	// parity of the descriptor just used
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			parity_r <= 1'b0;
			stat_ep_r <= 4'h0;
			stat_dir_r <= 1'b0;
		end
		else if (eng_done)
		begin
			parity_r <= ptr_odd[eng_done_ep];
			stat_ep_r <= eng_done_ep;
			stat_dir_r <= eng_done_dir_in;
		end
	end

	////////////////////////////////////////////////////////////////
	// descriptor table position of the last transaction
	// fixed descriptor slot
	// unused endpoints keep their slots, so the table has gaps
	always_comb
	begin
		desc_idx = {1'b0, stat_ep_r, stat_dir_r};
		case (pp_mode)
			USBPP_PP_ALL: desc_idx = {stat_ep_r, stat_dir_r, parity_r};
			USBPP_PP_EP0OUT:
			begin
				if (stat_ep_r == 4'h0 && !stat_dir_r)
					desc_idx = {5'h00, parity_r};
				else
					desc_idx = {1'b0, stat_ep_r, stat_dir_r} + 6'h01;
			end
			default: desc_idx = {1'b0, stat_ep_r, stat_dir_r};
		endcase
	end

	////////////////////////////////////////////////////////////////
	// wake synchroniser window
	// clear ignored while suspended, waiting for pll, or settling
	always_ff @(posedge core_clk)
	begin
		if (reset)
			wake_cnt_r <= 3'h0;
		else if (ctl_r[`USBPP_CTL_SUSPEND] || !pll_locked)
			wake_cnt_r <= 3'(`USBPP_WAKE_CYC);
		else if (wake_cnt_r != 3'h0)
			wake_cnt_r <= wake_cnt_r - 3'h1;
	end

	assign actv_clear_ok = wake_cnt_r == 3'h0 && !ctl_r[`USBPP_CTL_SUSPEND];

	////////////////////////////////////////////////////////////////
	// bus activity and idle flags
	// arm once per idle, fire once per resume
	always_ff @(posedge core_clk)
	begin
		if (reset)
			actv_armed_r <= 1'b0;
		else if (bus_idle_seen)
			actv_armed_r <= 1'b1;
		else if (bus_activity_seen)
			actv_armed_r <= 1'b0;
	end

	// set wins over clear; clear only when settled
	always_ff @(posedge core_clk)
	begin
		if (reset)
			actv_flag_r <= 1'b0;
		else if (bus_activity_seen && actv_armed_r && !bus_idle_seen)
			actv_flag_r <= 1'b1;
		else if (wr_irq && !reg_wdata[`USBPP_IRQ_ACTV] && actv_clear_ok)
			actv_flag_r <= 1'b0;
	end

	// idle flag sticky until written zero
	always_ff @(posedge core_clk)
	begin
		if (reset)
			idle_flag_r <= 1'b0;
		else if (bus_idle_seen)
			idle_flag_r <= 1'b1;
		else if (wr_irq && !reg_wdata[`USBPP_IRQ_IDLE])
			idle_flag_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// outputs and monitor
	// registered pin controls
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pullup_on <= 1'b0;
			regulator_on <= 1'b0;
			drive_monitor <= 1'b0;
			module_ready <= 1'b0;
		end
		else
		begin
			pullup_on <= cfg_r[`USBPP_CFG_PULLUP];
			regulator_on <= cfg_r[`USBPP_CFG_REGEN];
			drive_monitor <= (cfg_r[`USBPP_CFG_EXTXCVR] || cfg_r[`USBPP_CFG_MONEN]) && tx_active;
			module_ready <= ctl_r[`USBPP_CTL_ENABLE] && actv_clear_ok;
		end
	end

	////////////////////////////////////////////////////////////////
	// register read port
	always_ff @(posedge core_clk)
	begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`USBPP_ADDR_CFG: reg_rdata <= cfg_r;
				`USBPP_ADDR_CTL: reg_rdata <= ctl_r;
				`USBPP_ADDR_IRQ: reg_rdata <= 8'({idle_flag_r, 1'b0, actv_flag_r, 2'b00});
				`USBPP_ADDR_STAT: reg_rdata <= {1'b0, stat_ep_r, stat_dir_r, parity_r, 1'b0};
				`USBPP_ADDR_PTR: reg_rdata <= ptr_odd[7:0];
				`USBPP_ADDR_LINE: reg_rdata <= {6'h00, line_state};
				`USBPP_ADDR_DESC: reg_rdata <= {2'b00, desc_idx};
				default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	a_actv_once: assert property (@(posedge core_clk) disable iff (reset)
		(!actv_armed_r && !actv_flag_r && !bus_idle_seen) |=> !actv_flag_r)
		else $error("activity flag set without new idle");
	a_actv_hold_susp: assert property (@(posedge core_clk) disable iff (reset)
		(actv_flag_r && ctl_r[`USBPP_CTL_SUSPEND]) |=> actv_flag_r)
		else $error("activity flag cleared while suspended");
	a_idle_sticky: assert property (@(posedge core_clk) disable iff (reset)
		(idle_flag_r && !wr_irq) |=> idle_flag_r)
		else $error("idle flag dropped without write");
	a_pullup_follow: assert property (@(posedge core_clk) disable iff (reset)
		wr_cfg |=> ##1 pullup_on == $past(reg_wdata[`USBPP_CFG_PULLUP], 2))
		else $error("pull-up output not following config");
	a_eye_drives: assert property (@(posedge core_clk) disable iff (reset)
		(eye_on && !eye_prime_r) |=> (!xcvr_drive_enable_n && tx_plus_out != tx_minus_out))
		else $error("eye test not driving differential");
	a_parity_record: assert property (@(posedge core_clk) disable iff (reset)
		eng_done |=> parity_r == $past(ptr_odd[eng_done_ep]))
		else $error("parity bit not the pointer of the used descriptor");
	a_wake_block: assert property (@(posedge core_clk) disable iff (reset)
		(actv_flag_r && wake_cnt_r != 3'h0) |=> actv_flag_r)
		else $error("activity flag cleared inside wake window");
	a_monitor_drive: assert property (@(posedge core_clk) disable iff (reset)
		drive_monitor |-> !xcvr_drive_enable_n)
		else $error("drive monitor high while not driving");
	a_regulator_follow: assert property (@(posedge core_clk) disable iff (reset)
		wr_cfg |=> ##1 regulator_on == $past(reg_wdata[`USBPP_CFG_REGEN], 2))
		else $error("regulator output not following config");
endmodule // usbpp_core

/* File: src/usbpp_params.svh */
// constants for the usb line-coding, config and ping-pong pointer block
// assumes one 250 MHz core clock and a plain register port from firmware
`ifndef USBPP_PARAMS_SVH
`define USBPP_PARAMS_SVH
`define USBPP_ADDR_CFG 4'h0
`define USBPP_ADDR_CTL 4'h1
`define USBPP_ADDR_IRQ 4'h2
`define USBPP_ADDR_STAT 4'h3
`define USBPP_ADDR_PTR 4'h4
`define USBPP_ADDR_LINE 4'h5
`define USBPP_ADDR_DESC 4'h6
`define USBPP_CFG_PPMODE_LO 0
`define USBPP_CFG_FULLSPD 2
`define USBPP_CFG_EXTXCVR 3
`define USBPP_CFG_PULLUP 4
`define USBPP_CFG_REGEN 5
`define USBPP_CFG_MONEN 6
`define USBPP_CFG_EYE 7
`define USBPP_CTL_PTRRST 6
`define USBPP_CTL_ENABLE 3
`define USBPP_CTL_SUSPEND 1
`define USBPP_IRQ_ACTV 2
`define USBPP_IRQ_IDLE 4
`define USBPP_STAT_PARITY 1
`define USBPP_WAKE_NS 20
`define USBPP_CLK_NS 4
`define USBPP_WAKE_CYC ((`USBPP_WAKE_NS + `USBPP_CLK_NS - 1) / `USBPP_CLK_NS)
`define USBPP_NUM_EP 16
`endif

/* File: src/usbpp_pkg.sv */
// types shared by the usb ping-pong block
// assumes the params header is included by each user
package usbpp_pkg;
	typedef enum logic [1:0] {USBPP_PP_NONE, USBPP_PP_EP0OUT, USBPP_PP_ALL, USBPP_PP_RSVD} usbpp_ppmode_t;
	typedef enum logic [1:0] {USBPP_LINE_SE0, USBPP_LINE_LS, USBPP_LINE_FS, USBPP_LINE_ERR} usbpp_line_t;
endpackage

/* File: src/usbpp_line_codec.sv */
// line coding to and from the external transceiver
// assumes transceiver pins are synchronous to core_clk
`timescale 1ns/1ps
`include "usbpp_params.svh"
module usbpp_line_codec
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// engine side
	input wire logic tx_active,
	input wire logic tx_se0,
	input wire logic tx_bit,
	// transceiver receive pair
	input wire logic rx_plus_in,
	input wire logic rx_minus_in,
	// transceiver drive
	output logic tx_plus_out,
	output logic tx_minus_out,
	output logic xcvr_drive_enable_n,
	output usbpp_pkg::usbpp_line_t line_state
);
	import usbpp_pkg::*;
	always_ff @(posedge core_clk)
	begin
		if (reset || !tx_active || tx_se0)
		begin
			tx_plus_out <= 1'b0;
			tx_minus_out <= 1'b0;
		end
		else
		begin
			tx_plus_out <= tx_bit;
			tx_minus_out <= ~tx_bit;
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (reset)
			xcvr_drive_enable_n <= 1'b1;
		else
			xcvr_drive_enable_n <= ~tx_active;
	end
	always_ff @(posedge core_clk)
	begin
		if (reset)
			line_state <= USBPP_LINE_SE0;
		else
			line_state <= usbpp_line_t'({rx_plus_in, rx_minus_in});
	end
	a_no_illegal_pair: assert property (@(posedge core_clk) disable iff (reset) !(tx_plus_out && tx_minus_out))
		else $error("drive pair shows illegal 11");
	a_enable_follows_tx: assert property (@(posedge core_clk) disable iff (reset) tx_active |=> !xcvr_drive_enable_n)
		else $error("drive enable not low while transmitting");
	a_rx_decode: assert property (@(posedge core_clk) disable iff (reset) 1'b1 |=> line_state == usbpp_line_t'({$past(rx_plus_in), $past(rx_minus_in)}))
		else $error("receive decode wrong");
endmodule // usbpp_line_codec

/* File: src/usbpp_ptr_bank.sv */
// per-endpoint even/odd ping-pong pointers
// assumes completions arrive as one-cycle pulses
`timescale 1ns/1ps
`include "usbpp_params.svh"
module usbpp_ptr_bank
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// control
	input wire logic clear_all,
	input wire usbpp_pkg::usbpp_ppmode_t pp_mode,
	// completion
	input wire logic done_pulse,
	input wire logic [3:0] done_ep,
	input wire logic done_dir_in,
	// pointers
	output logic [`USBPP_NUM_EP-1:0] ptr_odd
);
	import usbpp_pkg::*;
	genvar g;
	generate
		for (g = 0; g < `USBPP_NUM_EP; g++)
		begin : g_ep
			logic pingpong_en;
			assign pingpong_en = (pp_mode == USBPP_PP_ALL) ||
				(pp_mode == USBPP_PP_EP0OUT && g == 0 && !done_dir_in);
			always_ff @(posedge core_clk)
			begin
				if (reset || clear_all)
					ptr_odd[g] <= 1'b0;
				else if (done_pulse && done_ep == 4'(g) && pingpong_en)
					ptr_odd[g] <= ~ptr_odd[g];
			end
		end
	endgenerate
	a_clear_to_even: assert property (@(posedge core_clk) disable iff (reset) clear_all |=> ptr_odd == '0)
		else $error("pointers not even after clear");
	a_ptr_toggle: assert property (@(posedge core_clk) disable iff (reset)
		(done_pulse && !clear_all && pp_mode == USBPP_PP_ALL) |=> ptr_odd[$past(done_ep)] != $past(ptr_odd[done_ep]))
		else $error("pointer did not toggle");
endmodule // usbpp_ptr_bank

/* File: tb/usbpp_xcvr_model.sv */
// behavioural external transceiver facing the usb line codec
// assumes pins are sampled on core_clk, bus_state set by the bench
`timescale 1ns/1ps
module usbpp_xcvr_model
(
	// clock
	input wire logic core_clk,
	// drive side from the device
	input wire logic tx_plus_out,
	input wire logic tx_minus_out,
	input wire logic xcvr_drive_enable_n,
	// bus condition seen while the device listens
	input wire logic [1:0] bus_state,
	// receive pair and monitor result
	output logic rx_plus_in,
	output logic rx_minus_in,
	output int illegal_count
);
	initial illegal_count = 0;
	always_comb
	begin
		if (!xcvr_drive_enable_n)
			{rx_plus_in, rx_minus_in} = {tx_plus_out, tx_minus_out};
		else
			{rx_plus_in, rx_minus_in} = bus_state;
	end
	always @(posedge core_clk)
	begin
		if (tx_plus_out === 1'b1 && tx_minus_out === 1'b1)
			illegal_count++;
	end
endmodule // usbpp_xcvr_model

/* File: tb/usbpp_core_bench.sv */
// self-checking bench for usbpp_core over its register port
// assumes one core_clk at 250 MHz and the params header on the path
`timescale 1ns/1ps
`include "usbpp_params.svh"
module usbpp_core_bench;
	logic core_clk, reset, reg_wr, reg_rd, eng_tx_active, eng_tx_se0, eng_tx_bit;
	logic eng_done, eng_done_dir_in, bus_idle_seen, bus_activity_seen, pll_locked;
	logic [3:0] reg_addr, eng_done_ep;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic [1:0] bus_state, p1, p2;
	logic rx_plus_in, rx_minus_in, tx_plus_out, tx_minus_out, xcvr_drive_enable_n;
	logic pullup_on, regulator_on, drive_monitor, module_ready;
	int fail_count, compares, illegal_count, i;
	usbpp_core u_usbpp_core (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.eng_tx_active(eng_tx_active), .eng_tx_se0(eng_tx_se0), .eng_tx_bit(eng_tx_bit),
		.eng_done(eng_done), .eng_done_ep(eng_done_ep), .eng_done_dir_in(eng_done_dir_in),
		.bus_idle_seen(bus_idle_seen), .bus_activity_seen(bus_activity_seen),
		.pll_locked(pll_locked), .rx_plus_in(rx_plus_in), .rx_minus_in(rx_minus_in),
		.tx_plus_out(tx_plus_out), .tx_minus_out(tx_minus_out),
		.xcvr_drive_enable_n(xcvr_drive_enable_n), .pullup_on(pullup_on),
		.regulator_on(regulator_on), .drive_monitor(drive_monitor), .module_ready(module_ready));
	usbpp_xcvr_model u_usbpp_xcvr_model (.core_clk(core_clk), .tx_plus_out(tx_plus_out),
		.tx_minus_out(tx_minus_out), .xcvr_drive_enable_n(xcvr_drive_enable_n),
		.bus_state(bus_state), .rx_plus_in(rx_plus_in), .rx_minus_in(rx_minus_in),
		.illegal_count(illegal_count));
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// data stands only in the cycle after the read edge
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		rd(a);
		chk($sformatf("reg%0h", a), exp, rv);
	endtask
	task automatic done(input logic [3:0] ep, input logic dir_in);
		@(posedge core_clk);
		eng_done <= 1'b1;
		eng_done_ep <= ep;
		eng_done_dir_in <= dir_in;
		@(posedge core_clk);
		eng_done <= 1'b0;
	endtask
	task automatic ev(input logic idle, input logic act);
		@(posedge core_clk);
		bus_idle_seen <= idle;
		bus_activity_seen <= act;
		@(posedge core_clk);
		bus_idle_seen <= 1'b0;
		bus_activity_seen <= 1'b0;
	endtask
	task automatic clear_loop();
		for (i = 0; i < 10; i++)
		begin
			rd(`USBPP_ADDR_IRQ);
			if (rv[`USBPP_IRQ_ACTV] === 1'b0)
				break;
			wr(`USBPP_ADDR_IRQ, 8'h00);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#80000;
		fail_count++;
		test_done();
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{reset, reg_wr, reg_rd, eng_tx_active, eng_tx_se0, eng_tx_bit, eng_done} = 7'h7F & 7'h40;
		{eng_done_dir_in, bus_idle_seen, bus_activity_seen, pll_locked} = 4'h1;
		{reg_addr, eng_done_ep, reg_wdata, bus_state} = 18'h00002;
		fail_count = 0;
		compares = 0;
		tick(6);
		reset <= 1'b0;
		#1 chk("oe_n", 8'h01, {7'h00, xcvr_drive_enable_n});
		chk("analog", 8'h00, {6'h00, pullup_on, regulator_on});
		rdc(`USBPP_ADDR_CFG, 8'h00);
		rdc(4'hF, 8'h00);
		for (int s = 0; s < 4; s++)
		begin
			@(posedge core_clk);
			bus_state <= s[1:0];
			tick(3);
			rdc(`USBPP_ADDR_LINE, {6'h00, s[1:0]});
		end
		for (int k = 0; k < 3; k++)
		begin
			@(posedge core_clk);
			eng_tx_active <= 1'b1;
			eng_tx_se0 <= (k == 0);
			eng_tx_bit <= (k == 2);
			tick(2);
			#1 chk("pins", k[7:0], {4'h0, drive_monitor, xcvr_drive_enable_n, tx_plus_out, tx_minus_out});
		end
		@(posedge core_clk);
		eng_tx_active <= 1'b0;
		tick(2);
		#1 chk("oe_n", 8'h01, {7'h00, xcvr_drive_enable_n});
		wr(`USBPP_ADDR_CFG, 8'h30);
		tick(2);
		#1 chk("analog", 8'h03, {6'h00, pullup_on, regulator_on});
		rdc(`USBPP_ADDR_CFG, 8'h30);
		// enable and set up before the eye test
		wr(`USBPP_ADDR_CTL, 8'h08);
		wr(`USBPP_ADDR_CFG, 8'hF0);
		tick(6);
		#1 p1 = {tx_plus_out, tx_minus_out};
		tick(1);
		#1 p2 = {tx_plus_out, tx_minus_out};
		chk("eye", 8'h06, {3'h0, xcvr_drive_enable_n, p1, p2});
		chk("monitor", 8'h01, {7'h00, drive_monitor});
		wr(`USBPP_ADDR_CFG, 8'h32);
		tick(3);
		#1 chk("oe_n", 8'h01, {7'h00, xcvr_drive_enable_n});
		chk("monitor", 8'h00, {7'h00, drive_monitor});
		wr(`USBPP_ADDR_CTL, 8'h00);
		wr(`USBPP_ADDR_CTL, 8'h08);
		rdc(`USBPP_ADDR_PTR, 8'h00);
		done(4'h3, 1'b0);
		rdc(`USBPP_ADDR_PTR, 8'h08);
		rdc(`USBPP_ADDR_STAT, 8'h18);
		rdc(`USBPP_ADDR_DESC, 8'h0C);
		done(4'h3, 1'b1);
		rdc(`USBPP_ADDR_PTR, 8'h00);
		rdc(`USBPP_ADDR_STAT, 8'h1E);
		rdc(`USBPP_ADDR_DESC, 8'h0F);
		done(4'h5, 1'b0);
		wr(`USBPP_ADDR_CTL, 8'h48);
		rdc(`USBPP_ADDR_PTR, 8'h00);
		wr(`USBPP_ADDR_CTL, 8'h08);
		done(4'h1, 1'b0);
		wr(`USBPP_ADDR_CTL, 8'h00);
		wr(`USBPP_ADDR_CTL, 8'h08);
		rdc(`USBPP_ADDR_PTR, 8'h00);
		wr(`USBPP_ADDR_CFG, 8'h31);
		done(4'h0, 1'b1);
		done(4'h2, 1'b0);
		rdc(`USBPP_ADDR_PTR, 8'h00);
		rdc(`USBPP_ADDR_DESC, 8'h05);
		done(4'h0, 1'b0);
		rdc(`USBPP_ADDR_PTR, 8'h01);
		wr(`USBPP_ADDR_CFG, 8'h30);
		done(4'h0, 1'b0);
		rdc(`USBPP_ADDR_PTR, 8'h01);
		done(4'h4, 1'b1);
		rdc(`USBPP_ADDR_DESC, 8'h09);
		ev(1'b0, 1'b1);
		rdc(`USBPP_ADDR_IRQ, 8'h00);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b1);
		tick(6);
		rdc(`USBPP_ADDR_IRQ, 8'h14);
		wr(`USBPP_ADDR_IRQ, 8'h00);
		ev(1'b0, 1'b1);
		rdc(`USBPP_ADDR_IRQ, 8'h00);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b1);
		wr(`USBPP_ADDR_CTL, 8'h0A);
		wr(`USBPP_ADDR_IRQ, 8'h00);
		rdc(`USBPP_ADDR_IRQ, 8'h04);
		wr(`USBPP_ADDR_CTL, 8'h08);
		wr(`USBPP_ADDR_IRQ, 8'h00);
		rdc(`USBPP_ADDR_IRQ, 8'h04);
		clear_loop();
		rdc(`USBPP_ADDR_IRQ, 8'h00);
		@(posedge core_clk);
		pll_locked <= 1'b0;
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b1);
		wr(`USBPP_ADDR_IRQ, 8'h00);
		rdc(`USBPP_ADDR_IRQ, 8'h04);
		chk("ready", 8'h00, {7'h00, module_ready});
		@(posedge core_clk);
		pll_locked <= 1'b1;
		tick(3);
		clear_loop();
		rdc(`USBPP_ADDR_IRQ, 8'h00);
		chk("ready", 8'h01, {7'h00, module_ready});
		chk("illegal", 8'h00, illegal_count[7:0]);
		test_done();
	end
endmodule // usbpp_core_bench
